// [dmc_buf2.v]
/*
 * dmc_buf2.v - two-entry buffer with valid/ready on both sides.
 * Assumes: both sides on sys_clk; rst asynchronous, active high.
 */
`timescale 1ns/1ps

module dmc_buf2 #(
    parameter W = 32
) (
    // clock and reset
    input wire sys_clk,
    input wire rst,
    // fill side
    input wire in_valid,
    output wire in_ready,
    input wire [W-1:0] in_data,
    // drain side
    output wire out_valid,
    input wire out_ready,
    output wire [W-1:0] out_data
);

reg [W-1:0] mem_q [0:1];
reg wp_q;
reg rp_q;
reg [1:0] level_q;
wire push;
wire pop;

assign in_ready = (level_q != 2'h2);
assign out_valid = (level_q != 2'h0);
assign out_data = mem_q[rp_q];
assign push = in_valid && in_ready;
assign pop = out_valid && out_ready;

// ----------------------------------------------------------------------
// storage
// ----------------------------------------------------------------------
always @(posedge sys_clk) begin
    if (push) begin
        mem_q[wp_q] <= in_data;
    end
end

// ----------------------------------------------------------------------
// pointers and fill level
// ----------------------------------------------------------------------
always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
        wp_q <= 1'b0;
        rp_q <= 1'b0;
        level_q <= 2'h0;
    end else begin
        if (push) begin
            wp_q <= ~wp_q;
        end
        if (pop) begin
            rp_q <= ~rp_q;
        end
        if (push && !pop) begin
            level_q <= level_q + 2'h1;
        end else if (pop && !push) begin
            level_q <= level_q - 2'h1;
        end
    end
end

endmodule

// [dmc_channel.v]
/*
 * dmc_channel.v - one dma channel: control register, address stepping,
 * transfer modes, reload and null writes, Avalon-MM register slave.
 * Assumes: read and write ports answer with ack on sys_clk; periph_trig
 * comes from logic on sys_clk; rst asynchronous, active high.
 */
// Register access over Avalon-MM and the register offsets were decided locally.
// What this block does
// - null write mode adds dummy source write
// - reload bit restores addresses and count
// - repeated modes always restore, ignoring reload
// - only original count kept, addresses recomputed
// - software request starts, clears on completion
// - transfers per request follow transfer mode
// - source mode 01 increments, 10 decrements
// - source mode 11 or 00 holds address
// - destination mode 01 increments, 10 decrements
// - destination mode 11 or 00 holds address
// - transfer mode selects one-shot/continuous/repeated
// - size bit: one byte, zero word
// - channel starts and issues reads only while channel_on set
`timescale 1ns/1ps
`include "dmc_map.vh"

module dmc_channel (
    // clock and reset
    input wire sys_clk,
    input wire rst,
    // register slave
    input wire [7:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    input wire [3:0] avs_byteenable,
    output wire [31:0] avs_readdata,
    output wire avs_waitrequest,
    // peripheral trigger
    input wire periph_trig,
    // source read port
    output wire rd_req,
    output wire [15:0] rd_addr,
    output wire [1:0] rd_be,
    input wire rd_ack,
    input wire [15:0] rd_data,
    // destination write port
    output wire wr_req,
    output wire [15:0] wr_addr,
    output wire [15:0] wr_data,
    output wire [1:0] wr_be,
    input wire wr_ack,
    // channel status
    output wire busy,
    output wire xfer_done
);

localparam W_IDLE = 2'h0;
localparam W_DST = 2'h1;
localparam W_NUL = 2'h2;

// ----------------------------------------------------------------------
// helper functions
// ----------------------------------------------------------------------
// byte step 1, word 2
function [15:0] step_of;
    input sz;
    begin
        step_of = sz ? 16'h0001 : 16'h0002;
    end
endfunction

function [15:0] adj_addr;
    input [15:0] a;
    input [1:0] mode;
    input sz;
    begin
        if (mode == `DMC_AM_INC) begin
            adj_addr = a + step_of(sz);
        end else if (mode == `DMC_AM_DEC) begin
            adj_addr = a - step_of(sz);
        end else begin
            adj_addr = a;
        end
    end
endfunction

// undoes n steps; a word step is n shifted left once
function [15:0] restore_addr;
    input [15:0] a;
    input [1:0] mode;
    input sz;
    input [15:0] n;
    reg [15:0] span;
    begin
        span = sz ? n : {n[14:0], 1'b0};
        if (mode == `DMC_AM_INC) begin
            restore_addr = a - span;
        end else if (mode == `DMC_AM_DEC) begin
            restore_addr = a + span;
        end else begin
            restore_addr = a;
        end
    end
endfunction

function [1:0] be_of;
    input a0;
    input sz;
    begin
        if (!sz) begin
            be_of = 2'h3;
        end else if (a0) begin
            be_of = 2'h2;
        end else begin
            be_of = 2'h1;
        end
    end
endfunction

function [15:0] merge16;
    input [15:0] old;
    input [15:0] nw;
    input [1:0] be;
    begin
        merge16 = {be[1] ? nw[15:8] : old[15:8], be[0] ? nw[7:0] : old[7:0]};
    end
endfunction

// ----------------------------------------------------------------------
// state
// ----------------------------------------------------------------------
reg [15:0] ctrl_q;
reg [15:0] src_q;
reg [15:0] dst_q;
reg [15:0] cnt_q;
reg [15:0] cnt_orig_q;
reg rld_pend_q;
reg busy_q;
reg done_q;
reg [15:0] rd_left_q;
reg [15:0] wr_left_q;
reg rd_req_q;
reg [15:0] rd_addr_q;
reg [1:0] rd_be_q;
reg [1:0] w_st_q;
reg wr_req_q;
reg [15:0] wr_addr_q;
reg [15:0] wr_data_q;
reg [1:0] wr_be_q;
reg [15:0] nul_addr_q;
reg nul_pend_q;
reg wait_q;
reg [31:0] rdata_q;

wire chon = ctrl_q[`DMC_B_CHON];
wire sz = ctrl_q[`DMC_B_SIZE];
wire [1:0] trm = ctrl_q[`DMC_B_TRM+1:`DMC_B_TRM];
wire [1:0] dam = ctrl_q[`DMC_B_DAM+1:`DMC_B_DAM];
wire [1:0] sam = ctrl_q[`DMC_B_SAM+1:`DMC_B_SAM];
wire swreq = ctrl_q[`DMC_B_SWREQ];
wire rld = ctrl_q[`DMC_B_RELOAD];
wire null_write_mode = ctrl_q[`DMC_B_NULL_WRITE_MODE];

// ----------------------------------------------------------------------
// bus decode
// ----------------------------------------------------------------------
wire bus_wr = avs_write && !wait_q;
wire [15:0] wd = avs_writedata[15:0];
wire [1:0] wbe = avs_byteenable[1:0];
wire wr_ctrl = bus_wr && (avs_address == `DMC_OFS_CTRL);
wire wr_src = bus_wr && (avs_address == `DMC_OFS_SRC);
wire wr_dst = bus_wr && (avs_address == `DMC_OFS_DST);
wire wr_cnt = bus_wr && (avs_address == `DMC_OFS_CNT);

// ----------------------------------------------------------------------
// transfer control terms
// ----------------------------------------------------------------------
wire [15:0] eff_cnt = rld_pend_q ? cnt_orig_q : cnt_q;
wire start = !busy_q && chon && (periph_trig || swreq) && (eff_cnt != 16'h0000);
wire [15:0] first_n = trm[1] ? eff_cnt : 16'h0001;

wire in_ready;
wire out_valid;
wire [31:0] out_data;
wire rd_fire = rd_req_q && rd_ack;
wire rd_issue = busy_q && chon && (rd_left_q != 16'h0000) && !rd_req_q && in_ready;
wire out_ready = (w_st_q == W_IDLE) && busy_q;
wire pop = out_valid && out_ready;
wire dst_fire = (w_st_q == W_DST) && wr_ack;
wire nul_fire = (w_st_q == W_NUL) && wr_ack;
wire word_end = (dst_fire && !nul_pend_q) || nul_fire;
// disabling the channel drains words already read, then stops
wire abort_end = busy_q && !chon && !rd_req_q && !out_valid && (w_st_q == W_IDLE);
wire op_end = (word_end && (wr_left_q == 16'h0001)) || abort_end;
wire cnt_zero = dst_fire ? (cnt_q == 16'h0001) : (cnt_q == 16'h0000);
wire blk_end = op_end && cnt_zero && !abort_end;

// word and its source address travel together for the null write
dmc_buf2 #(
    .W(32)
) u_buf (
    .sys_clk(sys_clk),
    .rst(rst),
    .in_valid(rd_fire),
    .in_ready(in_ready),
    .in_data({rd_addr_q, rd_data}),
    .out_valid(out_valid),
    .out_ready(out_ready),
    .out_data(out_data)
);

// ----------------------------------------------------------------------
// registers and sequencing
// ----------------------------------------------------------------------
always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
        ctrl_q <= `DMC_RST_CTRL;
        src_q <= `DMC_RST_ADDR;
        dst_q <= `DMC_RST_ADDR;
        cnt_q <= `DMC_RST_CNT;
        cnt_orig_q <= `DMC_RST_CNT;
        rld_pend_q <= 1'b0;
        busy_q <= 1'b0;
        done_q <= 1'b0;
        rd_left_q <= 16'h0000;
        wr_left_q <= 16'h0000;
        rd_req_q <= 1'b0;
        rd_addr_q <= 16'h0000;
        rd_be_q <= 2'h0;
        w_st_q <= W_IDLE;
        wr_req_q <= 1'b0;
        wr_addr_q <= 16'h0000;
        wr_data_q <= 16'h0000;
        wr_be_q <= 2'h0;
        nul_addr_q <= 16'h0000;
        nul_pend_q <= 1'b0;
    end else begin
        done_q <= op_end;
        // software writes first; hardware updates below take priority, except clearing swreq or chon that software sets
        if (wr_ctrl) begin
            ctrl_q <= merge16(ctrl_q, wd, wbe) & `DMC_CTRL_WMASK;
        end
        if (wr_src) begin
            src_q <= merge16(src_q, wd, wbe);
        end
        if (wr_dst) begin
            dst_q <= merge16(dst_q, wd, wbe);
        end
        if (wr_cnt) begin
            cnt_q <= merge16(cnt_q, wd, wbe);
            cnt_orig_q <= merge16(cnt_q, wd, wbe);
            rld_pend_q <= 1'b0;
        end
        if (start) begin
            busy_q <= 1'b1;
            rd_left_q <= first_n;
            wr_left_q <= first_n;
            // restore at start of next operation
            if (rld_pend_q) begin
                src_q <= restore_addr(src_q, sam, sz, cnt_orig_q);
                dst_q <= restore_addr(dst_q, dam, sz, cnt_orig_q);
                cnt_q <= cnt_orig_q;
                rld_pend_q <= 1'b0;
            end
        end
        // reader
        if (rd_issue) begin
            rd_req_q <= 1'b1;
            rd_addr_q <= src_q;
            rd_be_q <= be_of(src_q[0], sz);
        end
        if (rd_fire) begin
            rd_req_q <= 1'b0;
            rd_left_q <= rd_left_q - 16'h0001;
            src_q <= adj_addr(src_q, sam, sz);
        end
        if (!chon && !rd_req_q) begin
            rd_left_q <= 16'h0000;
        end
        // writer
        case (w_st_q)
            W_IDLE: begin
                if (pop) begin
                    w_st_q <= W_DST;
                    wr_req_q <= 1'b1;
                    wr_addr_q <= dst_q;
                    wr_data_q <= out_data[15:0];
                    wr_be_q <= be_of(dst_q[0], sz);
                    nul_addr_q <= out_data[31:16];
                    nul_pend_q <= null_write_mode;
                end
            end
            W_DST: begin
                if (wr_ack) begin
                    dst_q <= adj_addr(dst_q, dam, sz);
                    cnt_q <= cnt_q - 16'h0001;
                    if (nul_pend_q) begin
                        w_st_q <= W_NUL;
                        wr_addr_q <= nul_addr_q;
                        wr_be_q <= be_of(nul_addr_q[0], sz);
                    end else begin
                        w_st_q <= W_IDLE;
                        wr_req_q <= 1'b0;
                    end
                end
            end
            W_NUL: begin
                if (wr_ack) begin
                    w_st_q <= W_IDLE;
                    wr_req_q <= 1'b0;
                end
            end
            default: begin
                w_st_q <= W_IDLE;
                wr_req_q <= 1'b0;
            end
        endcase
        if (word_end) begin
            wr_left_q <= wr_left_q - 16'h0001;
        end
        if (op_end) begin
            busy_q <= 1'b0;
            wr_left_q <= 16'h0000;
            rd_left_q <= 16'h0000;
            if (!(wr_ctrl && wbe[1] && wd[`DMC_B_SWREQ])) begin
                ctrl_q[`DMC_B_SWREQ] <= 1'b0;
            end
        end
        if (blk_end) begin
            rld_pend_q <= rld || trm[0];
            if (!trm[0] && !(wr_ctrl && wbe[0] && wd[`DMC_B_CHON])) begin
                ctrl_q[`DMC_B_CHON] <= 1'b0;
            end
        end
    end
end

// ----------------------------------------------------------------------
// bus answer: one wait cycle per access
// ----------------------------------------------------------------------
always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
        wait_q <= 1'b1;
        rdata_q <= 32'h00000000;
    end else begin
        if (wait_q && (avs_read || avs_write)) begin
            wait_q <= 1'b0;
        end else begin
            wait_q <= 1'b1;
        end
        if (wait_q && avs_read) begin
            if (avs_address == `DMC_OFS_CTRL) begin
                rdata_q <= {16'h0000, ctrl_q};
            end else if (avs_address == `DMC_OFS_SRC) begin
                rdata_q <= {16'h0000, src_q};
            end else if (avs_address == `DMC_OFS_DST) begin
                rdata_q <= {16'h0000, dst_q};
            end else if (avs_address == `DMC_OFS_CNT) begin
                rdata_q <= {16'h0000, cnt_q};
            end else if (avs_address == `DMC_OFS_STAT) begin
                rdata_q <= {28'h0000000, !in_ready, out_valid, rld_pend_q, busy_q};
            end else begin
                rdata_q <= 32'h00000000;
            end
        end
    end
end

// ----------------------------------------------------------------------
// outputs
// ----------------------------------------------------------------------
assign avs_readdata = rdata_q;
assign avs_waitrequest = wait_q;
assign rd_req = rd_req_q;
assign rd_addr = rd_addr_q;
assign rd_be = rd_be_q;
assign wr_req = wr_req_q;
assign wr_addr = wr_addr_q;
assign wr_data = wr_data_q;
assign wr_be = wr_be_q;
assign busy = busy_q;
assign xfer_done = done_q;

endmodule

// [dmc_chk.sv]
/* dmc_chk.sv - port assertions for dmc_channel.
   Assumes: bound to dmc_channel from the testbench top file. */
`timescale 1ns/1ps
module dmc_chk (
    // clock and reset
    input wire sys_clk,
    input wire rst,
    // register bus
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_readdata,
    input wire avs_waitrequest,
    // memory ports
    input wire rd_req,
    input wire [15:0] rd_addr,
    input wire [1:0] rd_be,
    input wire rd_ack,
    input wire wr_req,
    input wire [15:0] wr_addr,
    input wire [15:0] wr_data,
    input wire [1:0] wr_be,
    input wire wr_ack,
    // status
    input wire busy,
    input wire xfer_done
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    // one low cycle, then back to waiting
    sequence ans_s;
        !avs_waitrequest ##1 avs_waitrequest;
    endsequence
    bus_answer_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> ans_s)
        else $error("bus answer not one cycle");
    bus_idle_a: assert property (!(avs_read || avs_write) && avs_waitrequest |=> avs_waitrequest)
        else $error("bus answered without request");
    read_upper_a: assert property (!avs_waitrequest |-> avs_readdata[31:16] == 16'h0000)
        else $error("upper read data not zero");
    read_hold_a: assert property (rd_req && !rd_ack |=> rd_req && $stable(rd_addr) && $stable(rd_be))
        else $error("read request changed before ack");
    write_hold_a: assert property (wr_req && !wr_ack |=> wr_req && $stable(wr_addr) && $stable(wr_data))
        else $error("write request changed before ack");
    read_lanes_a: assert property (rd_req |-> rd_be == 2'b11 || rd_be == (rd_addr[0] ? 2'b10 : 2'b01))
        else $error("read lanes wrong");
    write_lanes_a: assert property (wr_req |-> wr_be == 2'b11 || wr_be == (wr_addr[0] ? 2'b10 : 2'b01))
        else $error("write lanes wrong");
    idle_quiet_a: assert property (!busy |-> !rd_req && !wr_req)
        else $error("port request while idle");
    done_pulse_a: assert property (xfer_done |=> !xfer_done)
        else $error("done longer than one cycle");
    done_cause_a: assert property (xfer_done |-> $past(busy) || $past(busy, 2))
        else $error("done without operation");
endmodule

// [dmc_map.vh]
/*
 * dmc_map.vh - register offsets, control field positions, reset values
 * and mode encodings of the dma channel control block.
 * Assumes: included by bare name; definitions only.
 */
`ifndef DMC_MAP_VH
`define DMC_MAP_VH

// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define DMC_OFS_CTRL 8'h00
`define DMC_OFS_SRC 8'h04
`define DMC_OFS_DST 8'h08
`define DMC_OFS_CNT 8'h0C
`define DMC_OFS_STAT 8'h10

// ----------------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------------
`define DMC_B_CHON 0
`define DMC_B_SIZE 1
`define DMC_B_TRM 2
`define DMC_B_DAM 4
`define DMC_B_SAM 6
`define DMC_B_SWREQ 8
`define DMC_B_RELOAD 9
`define DMC_B_NULL_WRITE_MODE 10
`define DMC_CTRL_WMASK 16'h07FF

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define DMC_RST_CTRL 16'h0000
`define DMC_RST_ADDR 16'h0000
`define DMC_RST_CNT 16'h0000

// ----------------------------------------------------------------------
// address modes and transfer modes
// ----------------------------------------------------------------------
`define DMC_AM_FIX 2'h0
`define DMC_AM_INC 2'h1
`define DMC_AM_DEC 2'h2
`define DMC_AM_IND 2'h3
`define DMC_TRM_ONESHOT 2'h0
`define DMC_TRM_REP_ONESHOT 2'h1
`define DMC_TRM_CONT 2'h2
`define DMC_TRM_REP_CONT 2'h3

`endif

// [dmc_mem_model.sv]
/* dmc_mem_model.sv - memory side of the channel, logs every write.
   Assumes: same clock as dmc_channel; read data derive from the address. */
`timescale 1ns/1ps
module dmc_mem_model (
    // clock and reset
    input wire sys_clk,
    input wire rst,
    // stall select
    input wire slow,
    // read port
    input wire rd_req,
    input wire [15:0] rd_addr,
    output reg rd_ack,
    output wire [15:0] rd_data,
    // write port
    input wire wr_req,
    input wire [15:0] wr_addr,
    input wire [15:0] wr_data,
    output reg wr_ack
);
    reg [2:0] rd_wait_q;
    reg [2:0] wr_wait_q;
    reg [15:0] log_addr [0:31];
    reg [15:0] log_data [0:31];
    integer wr_n;
    // inverted outside the ack cycle so a stale capture shows up
    assign rd_data = rd_ack ? (rd_addr ^ 16'h5A00) : ~(rd_addr ^ 16'h5A00);
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            rd_ack <= 1'b0;
            wr_ack <= 1'b0;
            rd_wait_q <= 3'h0;
            wr_wait_q <= 3'h0;
            wr_n <= 0;
        end else begin
            rd_ack <= rd_req && !rd_ack && rd_wait_q >= {slow, slow, 1'b0};
            rd_wait_q <= (rd_req && !rd_ack) ? rd_wait_q + 3'h1 : 3'h0;
            wr_ack <= wr_req && !wr_ack && wr_wait_q >= {slow, slow, 1'b0};
            wr_wait_q <= (wr_req && !wr_ack) ? wr_wait_q + 3'h1 : 3'h0;
            if (wr_req && wr_ack) begin
                log_addr[wr_n[4:0]] <= wr_addr;
                log_data[wr_n[4:0]] <= wr_data;
                wr_n <= wr_n + 1;
            end
        end
    end
endmodule

// [testbench.sv]
/* testbench.sv - register-level tests of dmc_channel.
   Assumes: dmc_mem_model answers the ports; dmc_chk bound below. */
`timescale 1ns/1ps
`include "dmc_map.vh"
module testbench;
    reg sys_clk, rst, avs_read, avs_write, periph_trig, slow;
    reg [7:0] avs_address;
    reg [31:0] avs_writedata, rdv;
    reg [3:0] avs_byteenable;
    wire [31:0] avs_readdata;
    wire avs_waitrequest, rd_req, rd_ack, wr_req, wr_ack, busy, xfer_done;
    wire [15:0] rd_addr, rd_data, wr_addr, wr_data;
    wire [1:0] rd_be, wr_be;
    integer err_total, comparisons, cycles, base, i;
    reg [15:0] c, s, d;
    dmc_channel dmc_channel_inst (.sys_clk(sys_clk), .rst(rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .periph_trig(periph_trig), .rd_req(rd_req), .rd_addr(rd_addr), .rd_be(rd_be), .rd_ack(rd_ack),
        .rd_data(rd_data), .wr_req(wr_req), .wr_addr(wr_addr), .wr_data(wr_data), .wr_be(wr_be),
        .wr_ack(wr_ack), .busy(busy), .xfer_done(xfer_done));
    dmc_mem_model dmc_mem_model_inst (.sys_clk(sys_clk), .rst(rst), .slow(slow), .rd_req(rd_req),
        .rd_addr(rd_addr), .rd_ack(rd_ack), .rd_data(rd_data), .wr_req(wr_req), .wr_addr(wr_addr),
        .wr_data(wr_data), .wr_ack(wr_ack));
    always #50 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        cycles = cycles + 1;
        if (cycles == 20000) begin
            err_total = err_total + 1;
            results;
        end
    end
    task results;
        begin
            $display("comparisons %0d mismatches %0d", comparisons, err_total);
            if (err_total == 0 && comparisons > 0) begin
                $display("Test passed");
            end else begin
                $display("Test failed");
            end
            $finish;
        end
    endtask
    task chk(input string nm, input [31:0] e, input [31:0] g);
        begin
            comparisons = comparisons + 1;
            if (g !== e) begin
                err_total = err_total + 1;
                $display("unexpected %s: expected %h seen %h", nm, e, g);
            end
        end
    endtask
    // request held until waitrequest is sampled low
    task bus(input wr, input [7:0] a, input [15:0] v);
        integer n;
        begin
            @(posedge sys_clk);
            avs_address <= a;
            avs_writedata <= {16'h0000, v};
            avs_write <= wr;
            avs_read <= !wr;
            n = 0;
            @(posedge sys_clk);
            while (avs_waitrequest !== 1'b0 && n < 50) begin
                @(posedge sys_clk);
                n = n + 1;
            end
            chk("bus answer", 0, n / 50);
            rdv = avs_readdata;
            avs_write <= 1'b0;
            avs_read <= 1'b0;
        end
    endtask
    task rb(input [7:0] a, input string nm, input [15:0] e);
        begin
            bus(1'b0, a, 16'h0000);
            chk(nm, {16'h0000, e}, rdv);
        end
    endtask
    // no software request bit means a peripheral trigger starts it
    task go(input [15:0] cv, input [15:0] sv, input [15:0] dv, input [15:0] nv, input ld);
        integer k;
        begin
            if (ld) begin
                bus(1'b1, `DMC_OFS_SRC, sv);
                bus(1'b1, `DMC_OFS_DST, dv);
                bus(1'b1, `DMC_OFS_CNT, nv);
            end
            base = dmc_mem_model_inst.wr_n;
            bus(1'b1, `DMC_OFS_CTRL, cv);
            periph_trig <= !cv[`DMC_B_SWREQ];
            k = 0;
            do begin
                @(posedge sys_clk);
                periph_trig <= 1'b0;
                k = k + 1;
            end while (xfer_done !== 1'b1 && k < 300);
            chk("done", 1, xfer_done);
        end
    endtask
    function [15:0] stp(input [1:0] m, input sz);
        stp = (m == `DMC_AM_INC) ? (sz ? 16'h0001 : 16'h0002) : (m == `DMC_AM_DEC) ? (sz ? 16'hFFFF : 16'hFFFE) : 16'h0000;
    endfunction
    initial begin
        sys_clk = 1'b0;
        rst = 1'b1;
        {avs_read, avs_write, periph_trig, slow} = 4'h0;
        avs_address = 8'h00;
        avs_writedata = 32'h00000000;
        avs_byteenable = 4'h3;
        {err_total, comparisons, cycles} = 0;
        repeat (4) @(posedge sys_clk);
        rst <= 1'b0;
        rb(`DMC_OFS_CTRL, "ctrl reset", 16'h0000);
        rb(`DMC_OFS_CNT, "cnt reset", 16'h0000);
        rb(8'h20, "unmapped", 16'h0000);
        bus(1'b1, `DMC_OFS_CTRL, 16'hF800);
        rb(`DMC_OFS_CTRL, "ctrl reserved", 16'h0000);
        $display("test reset done");
        for (i = 0; i < 4; i = i + 1) begin
            c = {8'h01, i[1:0], 2'd3 - i[1:0], 2'b00, i[0], 1'b1};
            s = 16'h0100;
            d = 16'h0200 | i[0];
            go(c, s, d, 16'h0001, 1'b1);
            rb(`DMC_OFS_SRC, "src", s + stp(c[7:6], c[1]));
            rb(`DMC_OFS_DST, "dst", d + stp(c[5:4], c[1]));
            rb(`DMC_OFS_CNT, "cnt", 16'h0000);
            rb(`DMC_OFS_CTRL, "ctrl", c & 16'hFEFE);
            chk("wr count", base + 1, dmc_mem_model_inst.wr_n);
            chk("wr addr", d, dmc_mem_model_inst.log_addr[base]);
            chk("wr data", s ^ 16'h5A00, dmc_mem_model_inst.log_data[base]);
        end
        $display("test address modes done");
        slow <= 1'b1;
        s = 16'h0300;
        d = 16'h0400;
        go(16'h0759, s, d, 16'h0003, 1'b1);
        chk("wr count", base + 6, dmc_mem_model_inst.wr_n);
        for (i = 0; i < 3; i = i + 1) begin
            chk("dst write", d + 2 * i, dmc_mem_model_inst.log_addr[base + 2 * i]);
            chk("null write", s + 2 * i, dmc_mem_model_inst.log_addr[base + 2 * i + 1]);
        end
        rb(`DMC_OFS_SRC, "src", s + 16'h0006);
        rb(`DMC_OFS_STAT, "status", 16'h0002);
        go(16'h0759, s, d, 16'h0000, 1'b0);
        chk("reload dst", d, dmc_mem_model_inst.log_addr[base]);
        rb(`DMC_OFS_SRC, "src", s + 16'h0006);
        $display("test continuous reload done");
        slow <= 1'b0;
        s = 16'h0500;
        d = 16'h0600;
        go(16'h0155, s, d, 16'h0002, 1'b1);
        rb(`DMC_OFS_CTRL, "ctrl", 16'h0055);
        rb(`DMC_OFS_CNT, "cnt", 16'h0001);
        go(16'h0155, s, d, 16'h0000, 1'b0);
        go(16'h0155, s, d, 16'h0000, 1'b0);
        chk("restore dst", d, dmc_mem_model_inst.log_addr[base]);
        rb(`DMC_OFS_CNT, "cnt", 16'h0001);
        go(16'h015D, s, d, 16'h0002, 1'b1);
        chk("wr count", base + 2, dmc_mem_model_inst.wr_n);
        rb(`DMC_OFS_CTRL, "ctrl", 16'h005D);
        $display("test repeated done");
        base = dmc_mem_model_inst.wr_n;
        bus(1'b1, `DMC_OFS_CTRL, 16'h0100);
        repeat (20) @(posedge sys_clk);
        chk("idle busy", 0, busy);
        chk("idle writes", base, dmc_mem_model_inst.wr_n);
        go(16'h0001, 16'h0700, 16'h0800, 16'h0001, 1'b1);
        chk("trig writes", base + 1, dmc_mem_model_inst.wr_n);
        $display("test enable done");
        // channel switched off while its first read is outstanding
        slow <= 1'b1;
        base = dmc_mem_model_inst.wr_n;
        bus(1'b1, `DMC_OFS_CNT, 16'h0003);
        bus(1'b1, `DMC_OFS_CTRL, 16'h0109);
        bus(1'b1, `DMC_OFS_CTRL, 16'h0000);
        repeat (60) @(posedge sys_clk);
        chk("abort writes", base + 1, dmc_mem_model_inst.wr_n);
        chk("abort busy", 0, busy);
        rb(`DMC_OFS_CNT, "abort cnt", 16'h0002);
        $display("test disable done");
        results;
    end
endmodule
bind dmc_channel dmc_chk dmc_chk_inst (.sys_clk(sys_clk), .rst(rst), .avs_read(avs_read),
    .avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .rd_req(rd_req), .rd_addr(rd_addr), .rd_be(rd_be), .rd_ack(rd_ack), .wr_req(wr_req),
    .wr_addr(wr_addr), .wr_data(wr_data), .wr_be(wr_be), .wr_ack(wr_ack), .busy(busy),
    .xfer_done(xfer_done));
